// ===== design/free_run_line_timing_pkg.sv
/*
 * Constants for the free-running line timing generator: register byte
 * offsets, field positions, mode codes, reset values and timing figures.
 * Assumes a 25 MHz system clock and a word-wide register port.
 */
package free_run_line_timing_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 24;
   localparam int PIX_W = 16;

   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] CFG_OFS = 8'h04;
   localparam logic [7:0] LINE_ABS_OFS = 8'h08;
   localparam logic [7:0] LINE_RAW_OFS = 8'h0C;
   localparam logic [7:0] EXP_ABS_OFS = 8'h10;
   localparam logic [7:0] EXP_RAW_OFS = 8'h14;
   localparam logic [7:0] LINE_MIN_ABS_OFS = 8'h18;
   localparam logic [7:0] LINE_MIN_RAW_OFS = 8'h1C;
   localparam logic [7:0] ROI_LEN_OFS = 8'h20;
   localparam logic [7:0] SEG_PIX_OFS = 8'h24;
   localparam logic [7:0] STATUS_OFS = 8'h28;
   localparam logic [7:0] LINE_COUNT_OFS = 8'h2C;

   localparam logic [1:0] MODE_EDGE = 2'h0;
   localparam logic [1:0] MODE_PROG = 2'h1;

   localparam int CFG_AVG_LSB = 0;
   localparam int CFG_DUAL_BIT = 2;
   localparam int CFG_STAMP_BIT = 3;
   localparam int CFG_LINK80_BIT = 4;
   localparam int CFG_TAPS_LSB = 5;
   localparam logic [1:0] AVG_OFF = 2'h0;
   localparam logic [1:0] AVG_TWO = 2'h1;
   localparam logic [1:0] AVG_FOUR = 2'h2;

   localparam int ST_CTRL_BIT = 0;
   localparam int ST_INTEG_BIT = 1;
   localparam int ST_STRETCH_BIT = 2;
   localparam int ST_MODE_BIT = 3;

   localparam logic [CNT_W-1:0] LINE_RAW_RST = 24'h00_61A8;
   localparam logic [CNT_W-1:0] EXP_RAW_RST = 24'h00_09C4;
   localparam logic [PIX_W-1:0] ROI_LEN_RST = 16'h0800;
   localparam logic [PIX_W-1:0] SEG_PIX_RST = 16'h0800;

   // Fixed overhead added to every exposure, and the shortest high phase.
   localparam int EXP_OVH_NS = 1300;
   localparam int EXP_OVH_CYC = (EXP_OVH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CTRL_HIGH_NS = 100;
   localparam int CTRL_HIGH_CYC =
      (CTRL_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;

   localparam int READOUT_HZ = 16_000_000;
   localparam int READOUT_OVH_PIX = 224;
   localparam int STAMP_PIX = 16;
   localparam int GAP_40 = 16;
   localparam int GAP_80 = 24;
   localparam int LINK_MHZ = 40;
   // Reciprocal of cycles per microsecond, scaled by 2**30.
   localparam longint US_RECIP = 64'd42949673;
   localparam int US_RECIP_SH = 30;
endpackage

// ===== design/free_run_line_timing.sv
/*
 * Free-running internal line timing generator with its register port.
 * Assumes a single 25 MHz clock, synchronous active-high reset and a
 * register master that reads data one cycle after its read strobe.
 */
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Lines run from internal signal, no trigger.
// - Signal built from line period, exposure.
// - Lines follow back to back, no pause.
// - Line rate is reciprocal of period.
// - Only edge and programmable variants exist.
// - Edge variant integrates whole period.
// - Edge variant ignores falling edge.
// - Rising edge starts acquisition and readout.
// - Programmable variant integrates while signal low.
// - Exposure setting sets low time.
// - Mode field selects active variant.
// - Line period written absolute or raw.
// - Exposure written absolute or raw.
// - Max rate is smallest of four limits.
// - Exposure limit is N times the sum of exposure and 1.3us.
// - Minimum period readable in its own field.
// - Averaging sets exposure count two or four.
// - Readout limit from segment pixels plus 224.
// - Line stamp adds sixteen pixels.
// - Link gap 16 at 40MHz, 24 at 80MHz.
module free_run_line_timing #(
   parameter longint PIX_RATE_HZ = 64'd64_000_000,
   parameter logic [23:0] LINE_RAW_DEFAULT =
      free_run_line_timing_pkg::LINE_RAW_RST,
   parameter logic [23:0] EXP_RAW_DEFAULT =
      free_run_line_timing_pkg::EXP_RAW_RST
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [free_run_line_timing_pkg::ADDR_W-1:0] addr_i,
   input wire logic [free_run_line_timing_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [free_run_line_timing_pkg::DATA_W-1:0] rdata_o,
   output logic line_ctrl_o,
   output logic line_start_o,
   output logic integrate_o
);
   import free_run_line_timing_pkg::*;

   typedef enum logic [1:0] {
      ST_HIGH = 2'b01,
      ST_LOW = 2'b10
   } phase_t;

   localparam longint PROC_SCALE =
      (64'(CLK_HZ) * 64'd65536 + PIX_RATE_HZ - 64'd1) / PIX_RATE_HZ;

   logic [1:0] mode_q;
   logic [1:0] avg_q;
   logic dual_q;
   logic stamp_q;
   logic link80_q;
   logic [1:0] taps_q;
   logic [CNT_W-1:0] line_raw_q;
   logic [CNT_W-1:0] exp_raw_q;
   logic [PIX_W-1:0] roi_len_q;
   logic [PIX_W-1:0] seg_pix_q;
   logic [CNT_W-1:0] min_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] per_q;
   logic [CNT_W-1:0] low_at_q;
   logic [1:0] act_mode_q;
   logic stretch_q;
   logic [31:0] line_count_q;
   phase_t phase_q;
   logic [DATA_W-1:0] rdata_q;

   logic [63:0] exp_lim;
   logic [63:0] rd_lim;
   logic [63:0] proc_lim;
   logic [63:0] tx_lim;
   logic [63:0] pix;
   logic [63:0] tx_pix;
   logic [63:0] lim_max;
   logic [CNT_W-1:0] eff_per;
   logic [CNT_W-1:0] eff_exp;
   logic [CNT_W-1:0] floor_per;
   logic period_end;
   logic [1:0] act_mode_d;
   logic ctrl_low_d;

   function automatic logic [CNT_W-1:0] us_to_cyc(input logic [31:0] us);
      logic [63:0] p;
      p = 64'(us) * 64'(CYC_PER_US);
      us_to_cyc = (p > 64'((1 << CNT_W) - 1)) ? {CNT_W{1'b1}} : p[CNT_W-1:0];
   endfunction

   function automatic logic [31:0] cyc_to_us(input logic [CNT_W-1:0] c,
                                            input logic up);
      logic [63:0] p;
      p = (64'(c) + (up ? 64'(CYC_PER_US - 1) : 64'd0)) * US_RECIP;
      cyc_to_us = 32'(p >> US_RECIP_SH);
   endfunction

   // Software settings.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_q <= MODE_EDGE;
         avg_q <= AVG_OFF;
         dual_q <= 1'b0;
         stamp_q <= 1'b0;
         link80_q <= 1'b0;
         taps_q <= 2'h0;
         line_raw_q <= LINE_RAW_DEFAULT;
         exp_raw_q <= EXP_RAW_DEFAULT;
         roi_len_q <= ROI_LEN_RST;
         seg_pix_q <= SEG_PIX_RST;
      end else if (wr_i) begin
         case (addr_i)
            MODE_OFS: begin
               if (wdata_i[1:0] == MODE_EDGE || wdata_i[1:0] == MODE_PROG) begin
                  mode_q <= wdata_i[1:0];
               end
            end
            CFG_OFS: begin
               if (wdata_i[CFG_AVG_LSB+:2] != 2'h3) begin
                  avg_q <= wdata_i[CFG_AVG_LSB+:2];
               end
               dual_q <= wdata_i[CFG_DUAL_BIT];
               stamp_q <= wdata_i[CFG_STAMP_BIT];
               link80_q <= wdata_i[CFG_LINK80_BIT];
               taps_q <= wdata_i[CFG_TAPS_LSB+:2];
            end
            LINE_ABS_OFS: line_raw_q <= us_to_cyc(wdata_i);
            LINE_RAW_OFS: line_raw_q <= wdata_i[CNT_W-1:0];
            EXP_ABS_OFS: exp_raw_q <= us_to_cyc(wdata_i);
            EXP_RAW_OFS: exp_raw_q <= wdata_i[CNT_W-1:0];
            ROI_LEN_OFS: roi_len_q <= wdata_i[PIX_W-1:0];
            SEG_PIX_OFS: seg_pix_q <= wdata_i[PIX_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Four line rate limits, each expressed as a least period in cycles.
   always_comb begin
      pix = 64'(roi_len_q) + (stamp_q ? 64'(STAMP_PIX) : 64'd0);
      exp_lim = (64'(exp_raw_q) + 64'(EXP_OVH_CYC))
         << ((avg_q == AVG_FOUR) ? 2 : (avg_q == AVG_TWO) ? 1 : 0);
      rd_lim = ((64'(seg_pix_q) + 64'(READOUT_OVH_PIX)) * 64'(CYC_PER_US)
         + 64'((READOUT_HZ / 1_000_000) * (dual_q ? 2 : 1) - 1))
         >> (dual_q ? 5 : 4);
      proc_lim = (pix * PROC_SCALE + 64'd65535) >> 16;
      tx_pix = (64'(link80_q ? GAP_80 : GAP_40) << taps_q) + pix;
      // Link period per pixel clock is 25/40 = 5/8 of a system cycle.
      tx_lim = (tx_pix * 64'd5 + ((64'd8 << taps_q) << link80_q) - 64'd1)
         >> (3 + 32'(taps_q) + 32'(link80_q));
      lim_max = exp_lim;
      if (rd_lim > lim_max) begin
         lim_max = rd_lim;
      end
      if (proc_lim > lim_max) begin
         lim_max = proc_lim;
      end
      if (tx_lim > lim_max) begin
         lim_max = tx_lim;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         min_q <= LINE_RAW_RST;
      end else if (lim_max > 64'((1 << CNT_W) - 1)) begin
         min_q <= {CNT_W{1'b1}};
      end else begin
         min_q <= lim_max[CNT_W-1:0];
      end
   end

   // Period actually used: programmed value, stretched where too short.
   always_comb begin
      floor_per = CNT_W'(CTRL_HIGH_CYC + 1);
      eff_per = line_raw_q;
      if (min_q > eff_per) begin
         eff_per = min_q;
      end
      if (floor_per > eff_per) begin
         eff_per = floor_per;
      end
      eff_exp = exp_raw_q;
      if (eff_exp > eff_per - CNT_W'(CTRL_HIGH_CYC)) begin
         eff_exp = eff_per - CNT_W'(CTRL_HIGH_CYC);
      end
   end

   assign period_end = (cnt_q >= per_q - CNT_W'(1));

   // Period counter; it wraps to zero at the end of each line.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_q <= '0;
      end else if (period_end) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // Line settings are taken only when a new line begins.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         per_q <= LINE_RAW_RST;
         act_mode_q <= MODE_EDGE;
      end else if (period_end) begin
         per_q <= eff_per;
         act_mode_q <= mode_q;
      end
   end

   // Count at which the control signal falls within the line.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         low_at_q <= CNT_W'(CTRL_HIGH_CYC);
      end else if (period_end) begin
         if (mode_q == MODE_PROG) begin
            low_at_q <= eff_per - eff_exp;
         end else begin
            low_at_q <= CNT_W'(CTRL_HIGH_CYC);
         end
      end
   end

   // Marks a line whose period was stretched to the minimum.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         stretch_q <= 1'b0;
      end else if (period_end) begin
         stretch_q <= (min_q > line_raw_q);
      end
   end

   // Control signal phase: high from the rising edge, low until period end.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         phase_q <= ST_LOW;
      end else begin
         case (phase_q)
            ST_HIGH: begin
               if (period_end) begin
                  phase_q <= ST_HIGH;
               end else if (cnt_q + CNT_W'(1) >= low_at_q) begin
                  phase_q <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (period_end) begin
                  phase_q <= ST_HIGH;
               end
            end
            default: phase_q <= ST_LOW;
         endcase
      end
   end

   // Line start pulse, high in the first cycle of each line.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         line_start_o <= 1'b0;
      end else begin
         line_start_o <= period_end;
      end
   end

   // Number of lines started since reset.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         line_count_q <= '0;
      end else if (period_end) begin
         line_count_q <= line_count_q + 32'd1;
      end
   end

   // Mode and low phase of the next cycle, so integration lines up with it.
   assign act_mode_d = period_end ? mode_q : act_mode_q;
   assign ctrl_low_d = !period_end &&
      (phase_q == ST_LOW || cnt_q + CNT_W'(1) >= low_at_q);

   // Integration level: held high in edge mode, else registered from the next cycle's control phase.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         integrate_o <= 1'b0;
      end else if (act_mode_d == MODE_EDGE) begin
         integrate_o <= 1'b1;
      end else begin
         integrate_o <= ctrl_low_d;
      end
   end

   assign line_ctrl_o = (phase_q == ST_HIGH);

   // Read data, valid in the cycle after the read strobe.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= '0;
      end else if (rd_i) begin
         case (addr_i)
            MODE_OFS: rdata_q <= {30'h0, mode_q};
            CFG_OFS: rdata_q <= {25'h0, taps_q, link80_q, stamp_q, dual_q,
                                 avg_q};
            LINE_ABS_OFS: rdata_q <= cyc_to_us(line_raw_q, 1'b0);
            LINE_RAW_OFS: rdata_q <= 32'(line_raw_q);
            EXP_ABS_OFS: rdata_q <= cyc_to_us(exp_raw_q, 1'b0);
            EXP_RAW_OFS: rdata_q <= 32'(exp_raw_q);
            LINE_MIN_ABS_OFS: rdata_q <= cyc_to_us(min_q, 1'b1);
            LINE_MIN_RAW_OFS: rdata_q <= 32'(min_q);
            ROI_LEN_OFS: rdata_q <= 32'(roi_len_q);
            SEG_PIX_OFS: rdata_q <= 32'(seg_pix_q);
            STATUS_OFS: begin
               rdata_q <= '0;
               rdata_q[ST_CTRL_BIT] <= line_ctrl_o;
               rdata_q[ST_INTEG_BIT] <= integrate_o;
               rdata_q[ST_STRETCH_BIT] <= stretch_q;
               rdata_q[ST_MODE_BIT] <= act_mode_q[0];
            end
            LINE_COUNT_OFS: rdata_q <= line_count_q;
            default: rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   assign rdata_o = rdata_q;
endmodule // free_run_line_timing

`default_nettype wire

// ===== dv/free_run_line_timing_asserts.sv
/* Assertion checker for the free-running line timing generator.
   Sees only the top module's ports and is bound to every instance. */
`timescale 1ns/1ps
`default_nettype none
module free_run_line_timing_chk
   import free_run_line_timing_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic line_ctrl_o,
   input wire logic line_start_o,
   input wire logic integrate_o
);
   logic [1:0] mode_q;
   logic [1:0] act_q;
   logic [1:0] act_d;
   default clocking dcb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   // The mode in force for the line that starts now.
   assign act_d = line_start_o ? mode_q : act_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mode_q <= MODE_EDGE;
      end else if (wr_i && addr_i == MODE_OFS && wdata_i[1] == 1'b0) begin
         mode_q <= wdata_i[1:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         act_q <= MODE_EDGE;
      end else begin
         act_q <= act_d;
      end
   end
   chk_start_rise: assert property (line_start_o |-> line_ctrl_o &&
      !$past(line_ctrl_o)) else $error("line start without rising control");
   chk_rise_start: assert property ($rose(line_ctrl_o) |-> line_start_o)
      else $error("control rose without a line start");
   chk_start_pulse: assert property (line_start_o |=> !line_start_o)
      else $error("line start longer than one cycle");
   chk_high_min: assert property (line_start_o |-> line_ctrl_o[*3])
      else $error("control high phase too short");
   chk_edge_fall: assert property (line_start_o && act_d == MODE_EDGE
      |-> ##3 !line_ctrl_o) else $error("edge mode high phase wrong");
   chk_edge_integ: assert property (line_start_o && act_d == MODE_EDGE
      |=> integrate_o[*3]) else $error("edge mode not integrating");
   chk_prog_rise: assert property ($rose(line_ctrl_o) &&
      act_d == MODE_PROG |-> ##[0:1] !integrate_o)
      else $error("integrating while control high");
   chk_prog_fall: assert property ($fell(line_ctrl_o) &&
      act_q == MODE_PROG |-> ##[0:1] integrate_o)
      else $error("not integrating while control low");
   chk_rdata_idle: assert property (!$past(rd_i) |->
      rdata_o == 32'h0000_0000) else $error("read data outside read slot");
   chk_unmapped_rd: assert property (rd_i && addr_i > LINE_COUNT_OFS
      |=> rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
   cover property (line_start_o && act_d == MODE_PROG);
   cover property (line_start_o && act_d == MODE_EDGE);
   cover property (rd_i && addr_i == LINE_MIN_RAW_OFS);
endmodule // free_run_line_timing_chk
bind free_run_line_timing free_run_line_timing_chk u_chk (.clk_i(clk_i),
   .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .line_ctrl_o(line_ctrl_o),
   .line_start_o(line_start_o), .integrate_o(integrate_o));
`default_nettype wire

// ===== dv/line_sensor_model.sv
/* Behavioural model of the sensor exposure and readout circuitry.
   Assumes the system clock and the generator's line start and integrate. */
`timescale 1ns/1ps
`default_nettype none
module line_sensor_model (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic line_start_i,
   input wire logic integrate_i,
   output logic [23:0] period_o,
   output logic [23:0] exposure_o
);
   logic [23:0] cnt_q;
   logic [23:0] acc_q;
   // Each line start reads out the last line and opens a new one.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_q <= 24'h00_0000;
         acc_q <= 24'h00_0000;
         period_o <= 24'h00_0000;
         exposure_o <= 24'h00_0000;
      end else if (line_start_i) begin
         period_o <= cnt_q;
         exposure_o <= acc_q;
         cnt_q <= 24'h00_0001;
         acc_q <= {23'h00_0000, integrate_i};
      end else begin
         cnt_q <= cnt_q + 24'h00_0001;
         acc_q <= acc_q + {23'h00_0000, integrate_i};
      end
   end
endmodule // line_sensor_model
`default_nettype wire

// ===== dv/tb_free_run_line_timing.sv
/* Self-checking bench for the free-running line timing generator.
   Drives the register port and measures lines through the sensor model. */
`timescale 1ns/1ps
`default_nettype none
module tb_free_run_line_timing;
   import free_run_line_timing_pkg::*;
   localparam logic [7:0] CFG_T [8] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03,
      8'h04, 8'h04, 8'h0C};
   localparam logic [11:0] EXP_T [8] = '{12'h00A, 12'h1F4, 12'h1F4, 12'h1F4,
      12'h1F4, 12'h00A, 12'h00A, 12'h00A};
   localparam logic [11:0] LEN_T [8] = '{12'h010, 12'h010, 12'h010, 12'h010,
      12'h010, 12'h010, 12'h800, 12'h800};
   localparam logic [11:0] MIN_T [8] = '{12'h177, 12'h215, 12'h42A, 12'h854,
      12'h854, 12'h0BC, 12'h50A, 12'h514};
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = 8'h00;
   logic [DATA_W-1:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic line_ctrl_o;
   logic line_start_o;
   logic integrate_o;
   logic [23:0] period_w;
   logic [23:0] exposure_w;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   free_run_line_timing #(.LINE_RAW_DEFAULT(24'h00_0190)) u_dut (
      .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_ctrl_o(line_ctrl_o),
      .line_start_o(line_start_o), .integrate_o(integrate_o));
   line_sensor_model u_sensor (.clk_i(clk_i), .srst_i(srst_i),
      .line_start_i(line_start_o), .integrate_i(integrate_o),
      .period_o(period_w), .exposure_o(exposure_w));
   always #20 clk_i = ~clk_i;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] want);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      check(rdata_o, want);
   endtask
   task automatic wait_lines(input int n);
      repeat (n) begin
         @(negedge clk_i);
         while (line_start_o !== 1'b1) @(negedge clk_i);
      end
      @(negedge clk_i);
   endtask
   task automatic t_reset_values();
      rdc(LINE_RAW_OFS, 32'h0000_0190);
      rdc(EXP_RAW_OFS, 32'h0000_09C4);
      rdc(MODE_OFS, 32'h0000_0000);
      rdc(8'h30, 32'h0000_0000);
   endtask
   task automatic t_min_period();
      wr(SEG_PIX_OFS, 32'h0000_0010);
      for (int i = 0; i < 8; i++) begin
         wr(CFG_OFS, {24'h00_0000, CFG_T[i]});
         wr(EXP_RAW_OFS, {20'h0_0000, EXP_T[i]});
         wr(ROI_LEN_OFS, {20'h0_0000, LEN_T[i]});
         rdc(LINE_MIN_RAW_OFS, 32'(MIN_T[i]));
      end
      rdc(LINE_MIN_ABS_OFS, 32'h0000_0034);
      wr(CFG_OFS, 32'h0000_0074);
      rdc(CFG_OFS, 32'h0000_0074);
      rdc(LINE_MIN_RAW_OFS, 32'h0000_0320);
      wr(CFG_OFS, 32'h0000_0000);
      wr(ROI_LEN_OFS, 32'h0000_0010);
   endtask
   task automatic t_edge_period();
      wait_lines(3);
      check({8'h00, period_w}, 32'h0000_0190);
      check({8'h00, exposure_w}, 32'h0000_0190);
      rdc(LINE_COUNT_OFS, 32'h0000_0003);
      wr(LINE_RAW_OFS, 32'h0000_0064);
      wait_lines(3);
      check({8'h00, period_w}, 32'h0000_0177);
      rdc(STATUS_OFS, 32'h0000_0007);
      wr(LINE_ABS_OFS, 32'h0000_0014);
      rdc(LINE_RAW_OFS, 32'h0000_01F4);
      rdc(LINE_ABS_OFS, 32'h0000_0014);
      wait_lines(3);
      check({8'h00, period_w}, 32'h0000_01F4);
   endtask
   task automatic t_prog_mode();
      wait_lines(1);
      wr(MODE_OFS, {30'h0000_0000, MODE_PROG});
      wr(EXP_ABS_OFS, 32'h0000_0002);
      rdc(EXP_RAW_OFS, 32'h0000_0032);
      wait_lines(3);
      check({8'h00, exposure_w}, 32'h0000_0032);
      check({8'h00, period_w}, 32'h0000_01F4);
      rdc(STATUS_OFS, 32'h0000_0009);
      wr(MODE_OFS, 32'h0000_0002);
      rdc(MODE_OFS, 32'h0000_0001);
      wait_lines(1);
      wr(MODE_OFS, {30'h0000_0000, MODE_EDGE});
      wait_lines(3);
      check({8'h00, exposure_w}, 32'h0000_01F4);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      t_reset_values();
      t_min_period();
      t_edge_period();
      t_prog_mode();
      report_and_stop();
   end
endmodule // tb_free_run_line_timing
`default_nettype wire
